// ===== swu_map.svh
// Constants for the single-wire UART node addressing block
`ifndef SWU_MAP_SVH
`define SWU_MAP_SVH
`define SWU_SYNC_NIBBLE      4'h5
`define SWU_REPLY_ADDR       8'hff
`define SWU_BYTE_W           4
`define SWU_READ_LEN         4'h4
`define SWU_WRITE_LEN        4'h8
`define SWU_RW_BIT           7
`define SWU_CRC_INIT         8'h00
`define SWU_NODE_ADDR_RST    8'h00
`define SWU_CNT_RST          8'h00
`define SWU_STRAP_RING       3'h7
`define SWU_CLK_HZ           20000000
`define SWU_MIN_BAUD         9000
`define SWU_IDLE_BITS        63
`define SWU_GLITCH_CYC       16
`endif

// ===== swu_pkg.sv
// Types shared by the single-wire UART node block
package swu_pkg;
    typedef enum logic [1:0] {SWU_RX_IDLE, SWU_RX_START, SWU_RX_DATA, SWU_RX_STOP} swu_rx_st_t;

    // One received byte, presented for one cycle
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } swu_byte_t;

    // Datagram result handed to register logic
    typedef struct packed {
        logic        write_ok;
        logic        read_ok;
        logic [6:0]  reg_addr;
        logic [31:0] data;
    } swu_dgram_t;
endpackage

// ===== swu_rx_byte.sv
// Serial byte receiver with sync-nibble bit time measurement
`timescale 1ns/1ps
`include "swu_map.svh"
module swu_rx_byte
    import swu_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic      clock,
    input  wire logic      rst_b,
    input  wire logic      rx_in,
    input  wire logic      first_byte,
    output swu_byte_t      rx_byte,
    output logic           rx_busy
);
    initial begin
        if (CNT_W < 12) $error("swu_rx_byte: CNT_W too small for lowest baud rate");
    end

    typedef struct packed {
        swu_rx_st_t       st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] bit_len;
        logic [3:0]       idx;
        logic [7:0]       shreg;
        logic             prev;
        swu_byte_t        out;
    } swu_rx_state_t;

    swu_rx_state_t s_q, s_d;

    // Start bit found on falling edge; the first byte of a frame measures the bit time
    // over start plus three sync bits (four bits), later bytes reuse it.
    always_comb begin
        s_d           = s_q;
        s_d.prev      = rx_in;
        s_d.out.valid = 1'b0;
        s_d.cnt       = s_q.cnt + 1'b1;
        unique case (s_q.st)
            SWU_RX_IDLE: begin
                s_d.cnt = '0;
                if (s_q.prev && !rx_in) begin
                    s_d.st  = first_byte ? SWU_RX_START : SWU_RX_DATA;
                    s_d.idx = 4'h0;
                end
            end
            SWU_RX_START: begin
                // Falling edge from sync bit 2 to bit 3 ends the four-bit measurement
                if (s_q.prev && !rx_in && s_q.cnt > CNT_W'(`SWU_GLITCH_CYC)) begin
                    if (s_q.idx == 4'h0) begin
                        // Fall from sync bit 0 to bit 1 is passed over, it ends only two bits
                        s_d.idx = 4'h1;
                    end else begin
                        s_d.bit_len = s_q.cnt >> 2;
                        // Bits 2..0 of the sync (1,0,1) land low after five more shifts
                        s_d.shreg   = 8'ha0;
                        s_d.idx     = 4'h3;
                        s_d.cnt     = s_q.cnt >> 3;
                        s_d.st      = SWU_RX_DATA;
                    end
                end else if (&s_q.cnt) begin
                    s_d.st = SWU_RX_IDLE;
                end
            end
            SWU_RX_DATA: begin
                // Sample each data bit at its centre, LSB first
                if (s_q.cnt == s_q.bit_len + (s_q.idx == 4'h0 ? (s_q.bit_len >> 1) : '0)) begin
                    s_d.cnt = '0;
                    if (s_q.idx != 4'h0 || first_byte == 1'b0 || 1'b1) begin
                        s_d.shreg = {rx_in, s_q.shreg[7:1]};
                    end
                    s_d.idx = s_q.idx + 4'h1;
                    if (s_q.idx == 4'h7) begin
                        s_d.st = SWU_RX_STOP;
                    end
                end
            end
            SWU_RX_STOP: begin
                if (s_q.cnt == s_q.bit_len) begin
                    s_d.out.valid = rx_in;
                    s_d.out.data  = s_q.shreg;
                    s_d.st        = SWU_RX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s_q      <= '0;
            s_q.st   <= SWU_RX_IDLE;
            s_q.prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rx_byte = s_q.out;
    assign rx_busy = (s_q.st != SWU_RX_IDLE);
endmodule // swu_rx_byte

// ===== swu_node.sv
// Single-wire UART node: strap addressing, CRC check, filtering, counter, ring forward
// Functional notes
// - Strap offset weights: bit2 pin 4, bit1 pin 2, bit0 pin 1.
// - Node address equals programmed address plus strap offset, resampled every cycle until ring mode latches.
// - CRC-8 poly x^8+x^2+x+1, zero init, LSB first, includes sync.
// - Sync nibble contents never raise an error.
// - Act only on CRC-correct datagrams carrying our own address.
// - Each correct write datagram increments the datagram counter.
// - Counter is eight bits, wraps, untouched by reads.
// - Register address bit 7: zero read, one write.
// - Normal mode: pin is in and out; ring: input only, chain pin outputs.
// - Next-address output is high after reset until programmed low.
// - All straps high selects ring mode.
// - Direct strap addressing serves up to seven nodes.
// - Chained next-address output feeds following node's bit-0 strap.
// - Grounded first node answers 0; downstream high-input nodes answer 1.
// - Ring mode: output idles high until address programmed.
// - Ring mode: nonzero address forwards all input data to output.
// - Address 0xff reserved for replies; loads of 0xff are ignored, though programmed plus strap can still reach it.
`timescale 1ns/1ps
`include "swu_map.svh"
module swu_node
    import swu_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       single_wire_data_pin_in,
    output logic            single_wire_data_pin_out,
    output logic            single_wire_data_pin_oe,
    input  wire logic       addr_strap_bit2,
    input  wire logic       addr_strap_bit1,
    input  wire logic       addr_strap_bit0_chain_in,
    output logic            chain_next_out,
    input  wire logic [7:0] node_address_value,
    input  wire logic       node_address_load,
    input  wire logic       next_select_out_set,
    input  wire logic       next_select_out_clr,
    input  wire logic       tx_line,
    input  wire logic       tx_active,
    output logic [7:0]      node_addr_eff,
    output logic            ring_mode,
    output logic [7:0]      dgram_count,
    output swu_dgram_t      dgram,
    output logic            crc_error
);
    initial begin
        if (CNT_W < 12) $error("swu_node: CNT_W too small");
    end

    typedef struct packed {
        logic [1:0]  sw_sync;
        logic [2:0]  strap_s0;
        logic [2:0]  strap_s1;
        logic        strap_taken;
        logic [2:0]  strap;
        logic [7:0]  node_addr;
        logic        next_sel;
        logic [3:0]  byte_idx;
        logic [3:0]  dg_len;
        logic [7:0]  crc;
        logic [7:0]  addr_byte;
        logic [7:0]  reg_byte;
        logic [31:0] data;
        logic [7:0]  count;
        logic        chain_o;
        logic        sw_o;
        logic        sw_oe;
        swu_dgram_t  dg;
        logic        crc_err;
    } swu_node_state_t;

    swu_node_state_t s_q, s_d;
    swu_byte_t       rx_byte;
    logic            rx_busy;
    logic            ring;
    logic [7:0]      my_addr;

    // Byte receiver sees only the synchronised line
    swu_rx_byte #(.CNT_W(CNT_W)) u_rx (
        .clock      (clock),
        .rst_b      (rst_b),
        .rx_in      (s_q.sw_sync[1]),
        .first_byte (s_q.byte_idx == 4'h0),
        .rx_byte    (rx_byte),
        .rx_busy    (rx_busy)
    );

    // CRC over one byte, LSB first
    function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = {r[6:0], r[7] ^ r[1] ^ r[0] ^ b[i]};
        end
        return r;
    endfunction

    assign ring = (s_q.strap == `SWU_STRAP_RING) && s_q.strap_taken;
    // Programmed plus strap, direct offsets 0..6
    assign my_addr = s_q.node_addr + {5'h00, s_q.strap};

    always_comb begin
        s_d           = s_q;
        s_d.dg        = '0;
        s_d.crc_err   = 1'b0;
        // Straps are pins, so two stages before use
        s_d.sw_sync   = {s_q.sw_sync[0], single_wire_data_pin_in};
        s_d.strap_s0  = {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0_chain_in};
        s_d.strap_s1  = s_q.strap_s0;
        // Weighted strap sample taken once after reset
        if (!s_q.strap_taken) begin
            s_d.strap       = s_q.strap_s1;
            s_d.strap_taken = 1'b1;
        end
        // Chain input read continuously for downstream offset
        if (!ring && s_q.strap_taken) begin
            s_d.strap = s_q.strap_s1;
        end
        if (node_address_load && node_address_value != `SWU_REPLY_ADDR) begin
            s_d.node_addr = node_address_value;
        end
        if (next_select_out_clr) begin
            s_d.next_sel = 1'b0;
        end
        if (next_select_out_set) begin
            s_d.next_sel = 1'b1;
        end

        // Datagram assembly
        if (rx_byte.valid) begin
            s_d.byte_idx = s_q.byte_idx + 4'h1;
            // CRC accumulates sync through last data byte
            s_d.crc = crc_byte(s_q.byte_idx == 4'h0 ? `SWU_CRC_INIT : s_q.crc, rx_byte.data);
            unique case (s_q.byte_idx)
                4'h0: s_d.dg_len = `SWU_READ_LEN;
                4'h1: s_d.addr_byte = rx_byte.data;
                4'h2: begin
                    s_d.reg_byte = rx_byte.data;
                    s_d.dg_len = rx_byte.data[`SWU_RW_BIT] ? `SWU_WRITE_LEN : `SWU_READ_LEN;
                end
                default: ;
            endcase
            if (s_q.byte_idx >= 4'h3 && s_q.byte_idx < 4'h7) begin
                s_d.data = {s_q.data[23:0], rx_byte.data};
            end
            if (s_q.byte_idx == s_q.dg_len - 4'h1 && s_q.byte_idx != 4'h0) begin
                s_d.byte_idx = 4'h0;
                if (rx_byte.data == s_q.crc && s_q.addr_byte == my_addr) begin
                    s_d.dg.reg_addr = s_q.reg_byte[6:0];
                    s_d.dg.data     = s_q.data;
                    if (s_q.reg_byte[`SWU_RW_BIT]) begin
                        s_d.dg.write_ok = 1'b1;
                        s_d.count = s_q.count + 8'h01;
                    end else begin
                        s_d.dg.read_ok = 1'b1;
                    end
                end else if (rx_byte.data != s_q.crc) begin
                    s_d.crc_err = 1'b1;
                end
            end
        end

        if (ring) begin
            s_d.sw_oe = 1'b0;
            s_d.sw_o  = 1'b1;
            // Forward only once a nonzero address is held
            s_d.chain_o = (s_q.node_addr != 8'h00) ? s_q.sw_sync[1] : 1'b1;
        end else begin
            s_d.sw_oe   = tx_active;
            s_d.sw_o    = tx_line;
            // Chain output drives next node's bit-0 strap
            s_d.chain_o = s_q.next_sel;
        end
    end

    // All node state registered in one process
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s_q          <= '0;
            s_q.sw_sync  <= 2'b11;
            s_q.next_sel <= 1'b1;
            s_q.chain_o  <= 1'b1;
            s_q.sw_o     <= 1'b1;
            s_q.count    <= `SWU_CNT_RST;
            s_q.node_addr <= `SWU_NODE_ADDR_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops, except ring_mode and node_addr_eff, which are decoded from them
    assign single_wire_data_pin_out = s_q.sw_o;
    assign single_wire_data_pin_oe  = s_q.sw_oe;
    assign chain_next_out           = s_q.chain_o;
    assign dgram_count              = s_q.count;
    assign dgram                    = s_q.dg;
    assign crc_error                = s_q.crc_err;
    assign ring_mode                = ring;
    assign node_addr_eff            = my_addr;
endmodule // swu_node

// ===== swu_node_assertions.sv
// Concurrent checks on the single-wire UART node ports
`timescale 1ns/1ps
module swu_node_assertions
    import swu_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic       clock,
    input wire logic       rst_b,
    input wire logic       single_wire_data_pin_in,
    input wire logic       single_wire_data_pin_out,
    input wire logic       single_wire_data_pin_oe,
    input wire logic       addr_strap_bit2,
    input wire logic       addr_strap_bit1,
    input wire logic       addr_strap_bit0_chain_in,
    input wire logic       chain_next_out,
    input wire logic [7:0] node_address_value,
    input wire logic       node_address_load,
    input wire logic       next_select_out_set,
    input wire logic       next_select_out_clr,
    input wire logic       tx_line,
    input wire logic       tx_active,
    input wire logic [7:0] node_addr_eff,
    input wire logic       ring_mode,
    input wire logic [7:0] dgram_count,
    input wire swu_dgram_t dgram,
    input wire logic       crc_error
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Building blocks for the multi-step checks
    sequence straps_high;
        addr_strap_bit2 && addr_strap_bit1 && addr_strap_bit0_chain_in;
    endsequence
    sequence count_moved;
        dgram_count != $past(dgram_count);
    endsequence
    rst_idle_a: assert property ($rose(rst_b) |-> chain_next_out && !single_wire_data_pin_oe)
        else $error("outputs not idle after reset");
    cnt_step_a: assert property (count_moved |-> dgram_count == $past(dgram_count) + 8'h01)
        else $error("counter moved by other than one");
    cnt_cause_a: assert property (count_moved |-> dgram.write_ok || $past(dgram.write_ok)
        || $past(dgram.write_ok, 2))
        else $error("counter moved without a write");
    read_hold_a: assert property (dgram.read_ok |=> $stable(dgram_count))
        else $error("read changed the counter");
    pulse_excl_a: assert property (!(dgram.write_ok && (dgram.read_ok || crc_error)))
        else $error("accept and reject together");
    ring_input_a: assert property (ring_mode |-> !single_wire_data_pin_oe)
        else $error("pin driven in ring mode");
    ring_select_a: assert property (straps_high [*4] |-> ring_mode)
        else $error("ring mode not entered");
    tx_drive_a: assert property (!ring_mode && tx_active |=> single_wire_data_pin_oe
        && single_wire_data_pin_out == $past(tx_line))
        else $error("reply not put on pin");
    next_clr_a: assert property (!ring_mode && next_select_out_clr && !next_select_out_set
        |-> ##[1:3] !chain_next_out)
        else $error("next select not lowered");
    next_set_a: assert property (!ring_mode && next_select_out_set |-> ##[1:3] chain_next_out)
        else $error("next select not raised");
    addr_resv_a: assert property (node_address_load && node_address_value == 8'hff
        |=> $stable(node_addr_eff))
        else $error("reserved address accepted");
endmodule // swu_node_assertions

// ===== swu_host.sv
// Host-side model: frames datagrams onto the single-wire line
`timescale 1ns/1ps
module swu_host #(
    parameter int BIT_CYC = 32
) (
    input wire logic clock,
    output logic     host_tx
);
    // Line idles high, as the pull-up holds it
    initial host_tx = 1'b1;
    // CRC-8 step, zero start, LSB first
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = {r[6:0], r[7] ^ r[1] ^ r[0] ^ b[i]};
        end
        return r;
    endfunction
    // Start low, data LSB first, stop high; bits change on falling edges
    task automatic put_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            host_tx = f[i];
            repeat (BIT_CYC) @(negedge clock);
        end
    endtask
    // sync, node, register with direction, data high first, CRC
    task automatic send(input logic [7:0] node, input logic [6:0] ra, input logic wr,
                        input logic [31:0] d, input logic bad);
        logic [7:0] b [8];
        logic [7:0] crc;
        int n;
        n = wr ? 8 : 4;
        b = '{8'h05, node, {wr, ra}, d[31:24], d[23:16], d[15:8], d[7:0], 8'h00};
        crc = 8'h00;
        for (int i = 0; i < n - 1; i++) begin
            put_byte(b[i]);
            crc = crc_step(crc, b[i]);
        end
        // Corrupt one bit when a refusal is wanted
        put_byte(crc ^ {7'h00, bad});
    endtask
endmodule // swu_host

// ===== tb_swu_node.sv
// Directed testbench for the single-wire UART node
`timescale 1ns/1ps
module tb_swu_node;
    import swu_pkg::*;
    localparam int BIT_CYC = 32;
    localparam int CNT_W = 16;
    logic clock, rst_b, host_tx, line, s2, s1, s0, load, n_set, n_clr, tx_line, tx_active;
    logic pin_out, pin_oe, chain_out, ring, crc_err, chain_p, host_p;
    logic [7:0] addr_val, eff, count;
    logic [6:0] last_reg;
    logic [31:0] last_data;
    swu_dgram_t dgram;
    int err_total, n_checks, n_wr, n_rd, n_crc, n_fall, n_hfall;
    // Wire level: host idles high, node pulls low only while enabled
    assign line = host_tx & (pin_oe ? pin_out : 1'b1);
    swu_host #(.BIT_CYC(BIT_CYC)) host (.clock(clock), .host_tx(host_tx));
    swu_node #(.CNT_W(CNT_W)) dut (.clock(clock), .rst_b(rst_b), .single_wire_data_pin_in(line),
        .single_wire_data_pin_out(pin_out), .single_wire_data_pin_oe(pin_oe),
        .addr_strap_bit2(s2), .addr_strap_bit1(s1), .addr_strap_bit0_chain_in(s0),
        .chain_next_out(chain_out), .node_address_value(addr_val), .node_address_load(load),
        .next_select_out_set(n_set), .next_select_out_clr(n_clr), .tx_line(tx_line),
        .tx_active(tx_active), .node_addr_eff(eff), .ring_mode(ring), .dgram_count(count),
        .dgram(dgram), .crc_error(crc_err));
    // Clock at 20 MHz; all inputs start settled
    initial begin
        clock = 0;
        forever #25 clock = ~clock;
    end
    // Pulse and edge monitor; single-cycle outputs are caught where they stand
    always @(posedge clock) begin
        n_wr += dgram.write_ok;
        n_rd += dgram.read_ok;
        n_crc += crc_err;
        n_fall += (chain_p && !chain_out);
        n_hfall += (host_p && !line);
        chain_p <= chain_out;
        host_p <= line;
        if (dgram.write_ok) begin
            last_reg <= dgram.reg_addr;
            last_data <= dgram.data;
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Reset held two cycles, then room for strap synchronisers
    task automatic do_reset();
        rst_b = 0;
        cyc(2);
        rst_b = 1;
        cyc(4);
    endtask
    task automatic pulse(input logic st, input logic cl, input logic ld, input logic [7:0] v);
        {n_set, n_clr, load, addr_val} = {st, cl, ld, v};
        cyc(1);
        {n_set, n_clr, load} = 3'h0;
        cyc(4);
    endtask
    task automatic frame(input logic [7:0] nd, input logic wr, input logic bad);
        host.send(nd, 7'h22, wr, 32'ha1b2c3d4, bad);
        cyc(20 * BIT_CYC);
    endtask
    task automatic t_straps();
        for (int s = 0; s < 8; s++) begin
            {s2, s1, s0} = s[2:0];
            cyc(5);
            // weighted offset, all high selects ring
            if (s < 7) check("strap_eff", s, eff);
            check("ring", s == 7, ring);
        end
        $display("test straps done");
    endtask
    task automatic t_frames();
        // Ring mode from the strap test stays latched until a reset
        {s2, s1, s0} = 3'b011;
        do_reset();
        pulse(0, 0, 1, 8'h10);
        check("eff", 8'h13, eff);
        pulse(0, 0, 1, 8'hff);
        check("eff_resv", 8'h13, eff);
        {n_wr, n_rd, n_crc} = 0;
        frame(8'h13, 1, 0);
        check("wr", 1, n_wr);
        check("count", 8'h01, count);
        check("reg", 7'h22, last_reg);
        check("data", 32'ha1b2c3d4, last_data);
        frame(8'h13, 0, 0);
        check("rd", 1, n_rd);
        check("count_rd", 8'h01, count);
        frame(8'h14, 1, 0);
        check("wr_other", 1, n_wr);
        frame(8'h13, 1, 1);
        check("crc_err", 1, n_crc);
        check("count_bad", 8'h01, count);
        host.send(8'h13, 7'h22, 1, 32'ha1b2c3d4, 0);
        frame(8'h13, 1, 0);
        check("count_b2b", 8'h03, count);
        $display("test frames done");
    endtask
    task automatic t_chain();
        do_reset();
        {s2, s1, s0} = 3'b000;
        cyc(5);
        check("first_node", 8'h00, eff);
        check("nao_reset", 1, chain_out);
        check("count_rst", 8'h00, count);
        s0 = 1;
        cyc(5);
        check("downstream", 8'h01, eff);
        pulse(0, 1, 0, 8'h00);
        check("nao_clr", 0, chain_out);
        pulse(1, 1, 0, 8'h00);
        check("nao_set", 1, chain_out);
        s0 = 0;
        pulse(0, 0, 1, 8'hfd);
        check("desc_addr", 8'hfd, eff);
        {tx_active, tx_line} = 2'b10;
        cyc(2);
        check("tx_oe", 1, pin_oe);
        check("tx_out", 0, pin_out);
        {tx_active, tx_line} = 2'b01;
        cyc(2);
        $display("test chain done");
    endtask
    task automatic t_ring();
        do_reset();
        {s2, s1, s0} = 3'b111;
        cyc(5);
        n_fall = 0;
        frame(8'h07, 1, 0);
        check("ring_idle", 0, n_fall);
        check("ring_high", 1, chain_out);
        // unique nonzero address for this ring node
        pulse(0, 0, 1, 8'h05);
        {n_fall, n_hfall} = 0;
        frame(8'h30, 1, 0);
        check("ring_fwd", n_hfall, n_fall);
        check("ring_oe", 0, pin_oe);
        $display("test ring done");
    endtask
    // Main sequence
    initial begin
        {rst_b, s2, s1, s0, load, n_set, n_clr, tx_line, tx_active} = 9'h002;
        {addr_val, err_total, n_checks} = 0;
        cyc(2);
        rst_b = 1;
        cyc(4);
        t_straps();
        t_frames();
        t_chain();
        t_ring();
        give_verdict();
    end
    // Watchdog well beyond the expected run of about 24k cycles
    initial begin
        repeat (90000) @(posedge clock);
        err_total++;
        give_verdict();
    end
endmodule // tb_swu_node
bind swu_node swu_node_assertions #(.CNT_W(CNT_W)) u_chk (.clock(clock), .rst_b(rst_b),
    .single_wire_data_pin_in(single_wire_data_pin_in),
    .single_wire_data_pin_out(single_wire_data_pin_out),
    .single_wire_data_pin_oe(single_wire_data_pin_oe), .addr_strap_bit2(addr_strap_bit2),
    .addr_strap_bit1(addr_strap_bit1), .addr_strap_bit0_chain_in(addr_strap_bit0_chain_in),
    .chain_next_out(chain_next_out), .node_address_value(node_address_value),
    .node_address_load(node_address_load), .next_select_out_set(next_select_out_set),
    .next_select_out_clr(next_select_out_clr), .tx_line(tx_line), .tx_active(tx_active),
    .node_addr_eff(node_addr_eff), .ring_mode(ring_mode), .dgram_count(dgram_count),
    .dgram(dgram), .crc_error(crc_error));
